// ### rtl/dsm_pkg.sv
package dsm_pkg;
  // register bus shape
  localparam int DATA_W = 32;
  localparam int ADDR_W = 4;
  localparam int REG_W = 8;
  localparam int SEL_W = 4;
  localparam int NSRC = 16;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_SRC = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_HIGH = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_LOW = 4'hC;

  // control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_OINV_BIT = 4;
  localparam int CTRL_RDBK_BIT = 3;
  localparam int CTRL_SWBIT_BIT = 0;
  localparam logic [REG_W-1:0] CTRL_WMASK = 8'h91;
  localparam logic [REG_W-1:0] CTRL_RST = 8'h00;

  // source and carrier register fields
  localparam logic [REG_W-1:0] SRC_WMASK = 8'h0F;
  localparam logic [REG_W-1:0] CAR_WMASK = 8'h6F;
  localparam int CAR_INV_BIT = 6;
  localparam int CAR_SYNC_BIT = 5;
  localparam logic [REG_W-1:0] SEL_POR = 8'h00;

  // modulator source codes
  localparam logic [SEL_W-1:0] MOD_SW = 4'h0;
  localparam logic [SEL_W-1:0] MOD_PIN = 4'h1;
  localparam logic [SEL_W-1:0] MOD_CAPTURE_COMPARE_ONE = 4'h2;
  localparam logic [SEL_W-1:0] MOD_CAPTURE_COMPARE_TWO = 4'h3;
  localparam logic [SEL_W-1:0] MOD_PWMA = 4'h4;
  localparam logic [SEL_W-1:0] MOD_PWMB = 4'h5;
  localparam logic [SEL_W-1:0] MOD_CMP1 = 4'h6;
  localparam logic [SEL_W-1:0] MOD_CMP2 = 4'h7;
  localparam logic [SEL_W-1:0] MOD_SPI1 = 4'h8;
  localparam logic [SEL_W-1:0] MOD_SPI2 = 4'h9;
  localparam logic [SEL_W-1:0] MOD_UART = 4'hA;
  localparam logic [SEL_W-1:0] MOD_NCO = 4'hB;
  localparam logic [SEL_W-1:0] MOD_LC1 = 4'hC;

  // carrier source codes
  localparam logic [SEL_W-1:0] CAR_GND = 4'h0;
  localparam logic [SEL_W-1:0] CAR_PIN1 = 4'h1;
  localparam logic [SEL_W-1:0] CAR_PIN2 = 4'h2;
  localparam logic [SEL_W-1:0] CAR_REFCLK = 4'h3;
  localparam logic [SEL_W-1:0] CAR_CAPTURE_COMPARE_ONE = 4'h4;
  localparam logic [SEL_W-1:0] CAR_CAPTURE_COMPARE_TWO = 4'h5;
  localparam logic [SEL_W-1:0] CAR_PWMA = 4'h6;
  localparam logic [SEL_W-1:0] CAR_PWMB = 4'h7;
  localparam logic [SEL_W-1:0] CAR_NCO = 4'h8;
  localparam logic [SEL_W-1:0] CAR_RSVD = 4'h9;
  localparam logic [SEL_W-1:0] CAR_SYSCLK = 4'hA;
  localparam logic [SEL_W-1:0] CAR_FASTOSC = 4'hB;
  localparam logic [SEL_W-1:0] CAR_LC1 = 4'hC;

  // bus handshake states
  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_e;
endpackage : dsm_pkg

// ### rtl/sync3.sv
module sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // async levels in, clean levels out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  import dsm_pkg::*;

  generate
    if (W < 1) begin : g_bad_w
      $error("sync3 needs W of at least 1");
    end
  endgenerate

  logic [W-1:0] s1_r, s2_r, s3_r, out_r;
  logic [W-1:0] out_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // a bit moves only once stages two and three agree, filtering one-cycle glitches
  always_comb begin
    out_nxt = (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & out_r);
  end

  // first stage feeds only the second
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      out_r <= '0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign sync_o = out_r;
endmodule : sync3

// ### rtl/src_select.sv
module src_select #(
  parameter int SW = 4
) (
  // candidate sources, indexed by select code
  input wire logic [(1<<SW)-1:0] src_i,
  input wire logic [SW-1:0] sel_i,
  input wire logic invert_i,
  // chosen signal after polarity
  output logic sig_o
);
  generate
    if (SW < 1) begin : g_bad_sw
      $error("src_select needs SW of at least 1");
    end
  endgenerate

  // plain decode; polarity after the mux keeps one xor per path
  always_comb begin
    sig_o = src_i[sel_i] ^ invert_i;
  end
endmodule : src_select

// ### rtl/signal_modulator.sv
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
module signal_modulator
  import dsm_pkg::*;
(
  // clock, power-on reset, other device resets
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic dev_reset_i,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [DATA_W-1:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [DATA_W-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // on-chip sources, same clock
  input wire logic [3:0] logic_cell_i,
  input wire logic numeric_oscillator_out_i,
  input wire logic uart_transmit_out_i,
  input wire logic serial_port_one_data_out_i,
  input wire logic serial_port_two_data_out_i,
  input wire logic comparator_one_out_i,
  input wire logic comparator_two_out_i,
  input wire logic pulse_width_out_a_i,
  input wire logic pulse_width_out_b_i,
  input wire logic capture_compare_one_i,
  input wire logic capture_compare_two_i,
  // asynchronous sources
  input wire logic external_modulator_pin_i,
  input wire logic external_carrier_pin_one_i,
  input wire logic external_carrier_pin_two_i,
  input wire logic internal_fast_oscillator_i,
  input wire logic reference_clock_signal_i,
  // modulated output
  output logic signal_modulator_o
);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  bus_state_e state_r, state_nxt;
  logic wait_r, wait_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic [REG_W-1:0] ctrl_r, ctrl_nxt;
  logic [REG_W-1:0] src_r, src_nxt, high_r, high_nxt, low_r, low_nxt;
  logic [REG_W-1:0] rd_ctrl;
  logic [4:0] async_s;
  logic sysdiv_r, sysdiv_nxt;
  logic [NSRC-1:0] mod_vec, car_vec;
  logic mod_sig, hc, lc;
  logic hc_prev_r, lc_prev_r, hc_prev_nxt, lc_prev_nxt;
  logic hi_en_r, lo_en_r, hi_en_nxt, lo_en_nxt;
  logic fall_h, fall_l, mix, val;
  logic out_r, out_nxt, rdbk_r, rdbk_nxt;
  logic hsync, lsync;

  ////////////////////////////////////////////////////////////////////////////
  // pins and foreign clocks pass four flops before use
  sync3 #(.W(5)) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i({reference_clock_signal_i, internal_fast_oscillator_i,
              external_carrier_pin_two_i, external_carrier_pin_one_i,
              external_modulator_pin_i}),
    .sync_o(async_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register bus: one wait cycle, then answer
  always_comb begin
    rd_ctrl = ctrl_r;
    rd_ctrl[CTRL_RDBK_BIT] = rdbk_r;
  end

  always_comb begin
    state_nxt = state_r;
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    ctrl_nxt = ctrl_r;
    src_nxt = src_r;
    high_nxt = high_r;
    low_nxt = low_r;
    case (state_r)
      BUS_IDLE: begin
        if (avs_read_i || avs_write_i) begin
          state_nxt = BUS_ANSWER;
          wait_nxt = 1'b0;
          rdata_nxt = '0; // unmapped reads answer zero
          case (avs_address_i)
            OFS_CTRL: rdata_nxt[REG_W-1:0] = rd_ctrl;
            OFS_SRC: rdata_nxt[REG_W-1:0] = src_r;
            OFS_HIGH: rdata_nxt[REG_W-1:0] = high_r;
            OFS_LOW: rdata_nxt[REG_W-1:0] = low_r;
            default: rdata_nxt = '0;
          endcase
        end
      end
      BUS_ANSWER: begin
        state_nxt = BUS_IDLE;
        // write lands on the edge where waitrequest is seen low
        if (avs_write_i && avs_byteenable_i[0]) begin
          case (avs_address_i)
            OFS_CTRL: ctrl_nxt = avs_writedata_i[REG_W-1:0] & CTRL_WMASK;
            OFS_SRC: src_nxt = avs_writedata_i[REG_W-1:0] & SRC_WMASK;
            OFS_HIGH: high_nxt = avs_writedata_i[REG_W-1:0] & CAR_WMASK;
            OFS_LOW: low_nxt = avs_writedata_i[REG_W-1:0] & CAR_WMASK;
            default: ctrl_nxt = ctrl_r;
          endcase
        end
      end
      default: state_nxt = BUS_IDLE;
    endcase
    // device reset clears control only; selectors ride through it
    if (dev_reset_i) begin
      ctrl_nxt = CTRL_RST;
    end
  end

  // selectors have no defined reset in silicon; power-on gives zero here
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= BUS_IDLE;
      wait_r <= 1'b1;
      rdata_r <= '0;
      ctrl_r <= CTRL_RST;
      src_r <= SEL_POR;
      high_r <= SEL_POR;
      low_r <= SEL_POR;
    end else begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      src_r <= src_nxt;
      high_r <= high_nxt;
      low_r <= low_nxt;
    end
  end

  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // source vectors, indexed by select code
  always_comb begin
    mod_vec = '0;
    mod_vec[MOD_SW] = ctrl_r[CTRL_SWBIT_BIT];
    mod_vec[MOD_PIN] = async_s[0];
    mod_vec[MOD_CAPTURE_COMPARE_ONE] = capture_compare_one_i;
    mod_vec[MOD_CAPTURE_COMPARE_TWO] = capture_compare_two_i;
    mod_vec[MOD_PWMA] = pulse_width_out_a_i;
    mod_vec[MOD_PWMB] = pulse_width_out_b_i;
    mod_vec[MOD_CMP1] = comparator_one_out_i;
    mod_vec[MOD_CMP2] = comparator_two_out_i;
    mod_vec[MOD_SPI1] = serial_port_one_data_out_i;
    mod_vec[MOD_SPI2] = serial_port_two_data_out_i;
    mod_vec[MOD_UART] = uart_transmit_out_i;
    mod_vec[MOD_NCO] = numeric_oscillator_out_i;
    mod_vec[MOD_LC1 +: 4] = logic_cell_i;
    car_vec = '0;
    car_vec[CAR_GND] = 1'b0;
    car_vec[CAR_PIN1] = async_s[1];
    car_vec[CAR_PIN2] = async_s[2];
    car_vec[CAR_REFCLK] = async_s[4];
    car_vec[CAR_CAPTURE_COMPARE_ONE] = capture_compare_one_i;
    car_vec[CAR_CAPTURE_COMPARE_TWO] = capture_compare_two_i;
    car_vec[CAR_PWMA] = pulse_width_out_a_i;
    car_vec[CAR_PWMB] = pulse_width_out_b_i;
    car_vec[CAR_NCO] = numeric_oscillator_out_i;
    car_vec[CAR_RSVD] = 1'b0;
    car_vec[CAR_SYSCLK] = sysdiv_r;
    car_vec[CAR_FASTOSC] = async_s[3];
    car_vec[CAR_LC1 +: 4] = logic_cell_i;
  end

  // modulator never inverted; carriers share one decode
  src_select #(.SW(SEL_W)) u_mod_sel (
    .src_i(mod_vec),
    .sel_i(src_r[SEL_W-1:0]),
    .invert_i(1'b0),
    .sig_o(mod_sig)
  );

  src_select #(.SW(SEL_W)) u_high_sel (
    .src_i(car_vec),
    .sel_i(high_r[SEL_W-1:0]),
    .invert_i(high_r[CAR_INV_BIT]),
    .sig_o(hc)
  );

  src_select #(.SW(SEL_W)) u_low_sel (
    .src_i(car_vec),
    .sel_i(low_r[SEL_W-1:0]),
    .invert_i(low_r[CAR_INV_BIT]),
    .sig_o(lc)
  );

  ////////////////////////////////////////////////////////////////////////////
  // carrier gating and output
  // system clock cannot sample itself; its carrier is the clock halved
  always_comb begin
    hsync = high_r[CAR_SYNC_BIT];
    lsync = low_r[CAR_SYNC_BIT];
    sysdiv_nxt = ~sysdiv_r;
    hc_prev_nxt = hc;
    lc_prev_nxt = lc;
    fall_h = hc_prev_r & ~hc;
    fall_l = lc_prev_r & ~lc;
    // a synced carrier changes state only at its own falling edge
    hi_en_nxt = (!hsync || fall_h) ? mod_sig : hi_en_r;
    lo_en_nxt = (!lsync || fall_l) ? ~mod_sig : lo_en_r;
    mix = (hc & hi_en_r) | (lc & lo_en_r);
    val = mix ^ ctrl_r[CTRL_OINV_BIT];
    out_nxt = ctrl_r[CTRL_EN_BIT] ? val : 1'b0;
    rdbk_nxt = val;
    if (dev_reset_i) begin
      hi_en_nxt = 1'b0;
      lo_en_nxt = 1'b0;
      out_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sysdiv_r <= 1'b0;
      hc_prev_r <= 1'b0;
      lc_prev_r <= 1'b0;
      hi_en_r <= 1'b0;
      lo_en_r <= 1'b0;
      out_r <= 1'b0;
      rdbk_r <= 1'b0;
    end else begin
      sysdiv_r <= sysdiv_nxt;
      hc_prev_r <= hc_prev_nxt;
      lc_prev_r <= lc_prev_nxt;
      hi_en_r <= hi_en_nxt;
      lo_en_r <= lo_en_nxt;
      out_r <= out_nxt;
      rdbk_r <= rdbk_nxt;
    end
  end

  assign signal_modulator_o = out_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_SRC_UPPER_ZERO: assert property (src_r[REG_W-1:SEL_W] == '0)
    else $error("source register upper bits not zero");
  AST_MOD_NCO: assert property ((src_r[SEL_W-1:0] == MOD_NCO)
    |-> (mod_sig == numeric_oscillator_out_i))
    else $error("oscillator code does not pick oscillator");
  AST_MOD_CMP2: assert property ((src_r[SEL_W-1:0] == MOD_CMP2)
    |-> (mod_sig == comparator_two_out_i))
    else $error("comparator two code wrong");
  AST_MOD_PWMB: assert property ((src_r[SEL_W-1:0] == MOD_PWMB)
    |-> (mod_sig == pulse_width_out_b_i))
    else $error("pwm b code wrong");
  AST_MOD_SW: assert property ((src_r[SEL_W-1:0] == MOD_SW)
    |-> (mod_sig == ctrl_r[CTRL_SWBIT_BIT]))
    else $error("software bit not used as modulator");
  AST_SEL_HOLD: assert property ((dev_reset_i && state_r == BUS_IDLE)
    |=> (src_r == $past(src_r) && high_r == $past(high_r) && low_r == $past(low_r)))
    else $error("selector changed on device reset");
  AST_HI_INV: assert property ((high_r[SEL_W-1:0] == CAR_NCO)
    |-> (hc == (numeric_oscillator_out_i ^ high_r[CAR_INV_BIT])))
    else $error("high carrier polarity wrong");
  AST_HI_NOSYNC: assert property ((!hsync && mod_sig && !dev_reset_i)
    |=> hi_en_r)
    else $error("unsynced high carrier not immediate");
  AST_LO_PWMA: assert property ((low_r[SEL_W-1:0] == CAR_PWMA)
    |-> (lc == (pulse_width_out_a_i ^ low_r[CAR_INV_BIT])))
    else $error("low carrier pwm a decode wrong");
  AST_CAR_GND: assert property ((high_r[SEL_W-1:0] == CAR_GND)
    |-> (hc == high_r[CAR_INV_BIT]))
    else $error("ground carrier not low");
  AST_LO_SYNC_HOLD: assert property ((lsync && !fall_l && !dev_reset_i)
    |=> (lo_en_r == $past(lo_en_r)))
    else $error("synced low carrier moved without falling edge");
  AST_CAR_RSVD: assert property (((high_r | low_r) & ~CAR_WMASK) == '0)
    else $error("unimplemented carrier bit set");
  AST_DISABLED: assert property (!ctrl_r[CTRL_EN_BIT] |=> !signal_modulator_o)
    else $error("disabled modulator drives output");
  AST_HI_SYNC_WAIT: assert property ((hsync && !hi_en_r && mod_sig && !fall_h)
    |=> !hi_en_r)
    else $error("synced high carrier entered early");
  AST_OUT_VAL: assert property ((ctrl_r[CTRL_EN_BIT] && !dev_reset_i)
    |=> (signal_modulator_o == ($past(mix) ^ $past(ctrl_r[CTRL_OINV_BIT]))))
    else $error("output polarity wrong");
  AST_DEV_RST: assert property (dev_reset_i |=> (!ctrl_r[CTRL_EN_BIT] && !signal_modulator_o))
    else $error("device reset left modulator on");
  AST_MIX_HIGH: assert property ((ctrl_r[CTRL_EN_BIT] && !dev_reset_i && hi_en_r && !lo_en_r)
    |=> (signal_modulator_o == ($past(hc) ^ $past(ctrl_r[CTRL_OINV_BIT]))))
    else $error("mixer does not follow high carrier");
  AST_RSVD_LOW: assert property ((low_r[SEL_W-1:0] == CAR_RSVD)
    |-> (lc == low_r[CAR_INV_BIT]))
    else $error("reserved carrier not constant");
  AST_BUS_ANSWER: assert property ((state_r == BUS_IDLE && (avs_read_i || avs_write_i))
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not after one wait cycle");
endmodule : signal_modulator

// ### tb/src_model.sv
module src_model (
  // clock and wanted source levels
  input wire logic clk_i,
  input wire logic [18:0] lvl_i,
  // peripheral and pin levels, one bit each
  output logic [18:0] src_o
);
  timeunit 1ns;
  timeprecision 1ns;

  ////////////////////////////////////////////////////////////////////////
  // peripherals move just after an edge, like real same-clock logic
  always_ff @(posedge clk_i) begin
    src_o <= lvl_i;
  end
endmodule : src_model

// ### tb/testbench.sv
module testbench
  import dsm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // design pins
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic dev_reset_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [DATA_W-1:0] avs_writedata_i = '0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [DATA_W-1:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic signal_modulator_o;
  // bench state
  logic [18:0] lvl = '0;
  logic [18:0] src;
  logic [DATA_W-1:0] rdata;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  // source index behind each select code; unused slots hold 0
  int mod_idx [16] = '{0, 14, 12, 13, 10, 11, 8, 9, 6, 7, 5, 4, 0, 1, 2, 3};
  int car_idx [16] = '{0, 15, 16, 17, 12, 13, 10, 11, 4, 0, 0, 18, 0, 1, 2, 3};

  ////////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  src_model i_src (.clk_i(clk_i), .lvl_i(lvl), .src_o(src));

  signal_modulator i_dut (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .dev_reset_i(dev_reset_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .logic_cell_i(src[3:0]),
    .numeric_oscillator_out_i(src[4]),
    .uart_transmit_out_i(src[5]),
    .serial_port_one_data_out_i(src[6]),
    .serial_port_two_data_out_i(src[7]),
    .comparator_one_out_i(src[8]),
    .comparator_two_out_i(src[9]),
    .pulse_width_out_a_i(src[10]),
    .pulse_width_out_b_i(src[11]),
    .capture_compare_one_i(src[12]),
    .capture_compare_two_i(src[13]),
    .external_modulator_pin_i(src[14]),
    .external_carrier_pin_one_i(src[15]),
    .external_carrier_pin_two_i(src[16]),
    .reference_clock_signal_i(src[17]),
    .internal_fast_oscillator_i(src[18]),
    .signal_modulator_o(signal_modulator_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // verdict, reached from the main sequence or the watchdog
  task close_out;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out

  task chk_rd(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask : chk_rd

  task chk_out(input logic exp);
    n_checks++;
    if (signal_modulator_o !== exp) begin
      fail_count++;
      $display("Error at %0t: output %h expected %h", $time, signal_modulator_o, exp);
    end
  endtask : chk_out

  // one bus cycle; request held until waitrequest is seen low at an edge
  task xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d,
            input logic [3:0] be);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= ~w;
    avs_writedata_i <= {24'h0, d};
    avs_byteenable_i <= be;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rdata = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : xfer

  task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask : wr

  task rd(input logic [ADDR_W-1:0] a);
    xfer(1'b0, a, 8'h00, 4'hF);
  endtask : rd

  // synced carrier "so" on cell one, other carrier ground
  task sync_chk(input logic [ADDR_W-1:0] so, input logic [7:0] c_on, c_off);
    lvl <= 19'h1;
    wr(so, 8'h0C);
    wr(OFS_CTRL, c_on);
    repeat (8) @(posedge clk_i);
    chk_out(1'b1);
    wr(OFS_CTRL, c_off);
    repeat (8) @(posedge clk_i);
    chk_out(1'b0);
    wr(so, 8'h2C);
    wr(OFS_CTRL, c_on);
    repeat (8) @(posedge clk_i);
    chk_out(1'b0);
    lvl <= 19'h0;
    repeat (2) @(posedge clk_i);
    lvl <= 19'h1;
    repeat (8) @(posedge clk_i);
    chk_out(1'b1);
    wr(OFS_CTRL, c_off);
    repeat (8) @(posedge clk_i);
    chk_out(1'b1);
    lvl <= 19'h0;
    repeat (8) @(posedge clk_i);
    chk_out(1'b0);
  endtask : sync_chk

  ////////////////////////////////////////////////////////////////////////
  // watchdog: whole run needs well under this many cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      fail_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [ADDR_W-1:0] ofs;
    logic v;
    logic inv;
    int ones;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    // power-on values, then writable masks
    rd(OFS_CTRL);
    chk_rd(rdata, {24'h0, CTRL_RST});
    rd(OFS_SRC);
    chk_rd(rdata, {24'h0, SEL_POR});
    wr(OFS_SRC, 8'hFF);
    rd(OFS_SRC);
    chk_rd(rdata, 32'h0F);
    wr(OFS_HIGH, 8'hFF);
    rd(OFS_HIGH);
    chk_rd(rdata, 32'h6F);
    wr(OFS_LOW, 8'hFF);
    rd(OFS_LOW);
    chk_rd(rdata, 32'h6F);
    wr(OFS_CTRL, 8'hFF);
    rd(OFS_CTRL);
    chk_rd(rdata & 32'hF7, 32'h91);
    // masked byte lane and unmapped address leave the source register alone
    xfer(1'b1, OFS_SRC, 8'h00, 4'h0);
    xfer(1'b1, 4'h2, 8'h00, 4'hF);
    rd(OFS_SRC);
    chk_rd(rdata, 32'h0F);
    rd(4'h2);
    chk_rd(rdata, 32'h0);
    // every modulator code; high carrier forced 1, low carrier ground
    wr(OFS_HIGH, 8'h40);
    wr(OFS_LOW, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(OFS_SRC, 8'(c));
      for (int k = 0; k < 2; k++) begin
        v = k[0];
        lvl <= v ? (19'h1 << mod_idx[c]) : ~(19'h1 << mod_idx[c]);
        wr(OFS_CTRL, (c == 0) ? {7'h40, v} : 8'h80);
        repeat (8) @(posedge clk_i);
        chk_out(v);
      end
    end
    // every carrier code on both carriers, both polarities except system clock
    wr(OFS_SRC, 8'h00);
    for (int h = 0; h < 2; h++) begin
      ofs = (h == 0) ? OFS_HIGH : OFS_LOW;
      wr((h == 0) ? OFS_LOW : OFS_HIGH, 8'h00);
      wr(OFS_CTRL, (h == 0) ? 8'h81 : 8'h80);
      for (int c = 0; c < 16; c++) begin
        if (c == 10) begin
          wr(ofs, 8'h0A);
          repeat (8) @(posedge clk_i);
          ones = 0;
          repeat (4) begin
            @(posedge clk_i);
            ones += int'(signal_modulator_o === 1'b1);
          end
          chk_rd(32'(ones), 32'h2);
        end else begin
          for (int k = 0; k < 4; k++) begin
            v = k[0];
            inv = k[1];
            lvl <= v ? (19'h1 << car_idx[c]) : ~(19'h1 << car_idx[c]);
            wr(ofs, {1'b0, inv, 2'b00, 4'(c)});
            repeat (8) @(posedge clk_i);
            chk_out(((c == 0 || c == 9) ? 1'b0 : v) ^ inv);
          end
        end
      end
    end
    // carrier synchronisation on each side
    wr(OFS_HIGH, 8'h00);
    wr(OFS_LOW, 8'h00);
    sync_chk(OFS_HIGH, 8'h81, 8'h80);
    wr(OFS_HIGH, 8'h00);
    sync_chk(OFS_LOW, 8'h80, 8'h81);
    // enable gating, output polarity, readback
    wr(OFS_LOW, 8'h00);
    wr(OFS_CTRL, 8'h10);
    repeat (8) @(posedge clk_i);
    chk_out(1'b0);
    rd(OFS_CTRL);
    chk_rd(rdata, 32'h18);
    wr(OFS_CTRL, 8'h90);
    repeat (8) @(posedge clk_i);
    chk_out(1'b1);
    wr(OFS_CTRL, 8'h80);
    repeat (8) @(posedge clk_i);
    chk_out(1'b0);
    // device reset clears control, keeps selectors
    wr(OFS_SRC, 8'h05);
    wr(OFS_HIGH, 8'h6B);
    wr(OFS_LOW, 8'h29);
    wr(OFS_CTRL, 8'h91);
    @(posedge clk_i);
    dev_reset_i <= 1'b1;
    @(posedge clk_i);
    dev_reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    chk_out(1'b0);
    rd(OFS_CTRL);
    chk_rd(rdata & 32'hF7, 32'h0);
    rd(OFS_SRC);
    chk_rd(rdata, 32'h05);
    rd(OFS_HIGH);
    chk_rd(rdata, 32'h6B);
    rd(OFS_LOW);
    chk_rd(rdata, 32'h29);
    // second power-on reset in mid-run
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(OFS_SRC);
    chk_rd(rdata, {24'h0, SEL_POR});
    close_out();
  end
endmodule : testbench
